/* File: inc/dap_defines.svh */
// Register map, field positions and constants of the accumulator post-processing block
`ifndef DAP_DEFINES_SVH
`define DAP_DEFINES_SVH
`define DAP_CFG_IDX       3'h0
`define DAP_INT_IDX       3'h1
`define DAP_STAT_IDX      3'h2
`define DAP_PTR_IDX       3'h3
`define DAP_CLIPA_EN_BIT  7
`define DAP_CLIPB_EN_BIT  6
`define DAP_WCLIP_EN_BIT  5
`define DAP_WIDTH_BIT     4
`define DAP_RND_BIT       1
`define DAP_TRAP_EN_BIT   0
`define DAP_ST_CLIPA_BIT  0
`define DAP_ST_CLIPB_BIT  1
`define DAP_ST_GRDA_BIT   2
`define DAP_ST_GRDB_BIT   3
`define DAP_ST_ANYG_BIT   4
`define DAP_ST_ANYC_BIT   5
`define DAP_ST_TRAP_BIT   6
`define DAP_CFG_RST       8'h00
`define DAP_PTR_RST       16'h0000
`define DAP_PTR_STEP      16'h0002
`define DAP_MAX40         40'h7FFFFFFFFF
`define DAP_MIN40         40'h8000000000
`define DAP_MAX32         40'h007FFFFFFF
`define DAP_MIN32         40'hFF80000000
`define DAP_HALF_LSW      16'h8000
`define DAP_WMAX          16'h7FFF
`define DAP_WMIN          16'h8000
`define DAP_SHIFT_MAX     5'h10
`endif

/* File: inc/dap_pkg.sv */
// Types of the accumulator post-processing block
package dap_pkg;
  typedef enum logic [2:0] {
    dap_op_mac_acc,
    dap_op_mac_sub,
    dap_op_move_sac,
    dap_op_clear,
    dap_op_multiply,
    dap_op_neg_multiply,
    dap_op_sq_dist,
    dap_op_sq_dist_acc
  } dap_op_t;
  typedef enum logic [1:0] {
    dap_src_acc_a,
    dap_src_acc_b,
    dap_src_xbus
  } dap_src_t;
endpackage

/* File: src/dap_post_proc.sv */
// Accumulator saturation, rounding, store saturation and barrel shifter
`timescale 1ns/1ps
`include "dap_defines.svh"
//
// Contract
// RULE1: Clip flags update on each adder pass, stay set until software clears.
// RULE2: Without saturation, clip flag records bit 39 overflow of its accumulator.
// RULE3: Saturation off and fatal trap enabled: set clip flag requests trap.
// RULE4: Status shows OR of guard flags and OR of clip flags.
// RULE5: 40-bit mode overflow loads max or min 40-bit value, sets clip flag.
// RULE6: 32-bit mode overflow loads max or min 32-bit value, sets clip flag.
// RULE7: In 32-bit saturation mode guard flags never become set.
// RULE8: Overflow mode wraps accumulator; adder bit 39 overflow sets clip flag.
// RULE9: Overflow mode with fatal trap enabled lets bit 39 overflow request trap.
// RULE10: Eligible multiply-accumulate ops may store rounded other accumulator high word.
// RULE11: Register-direct write-back puts rounded word into the pointer register.
// RULE12: Post-increment write-back stores at pointer, then pointer grows by two.
// RULE13: Rounding mode selects conventional or convergent; no rounding truncates.
// RULE14: Conventional rounding increments high word when low word is 0x8000 or more.
// RULE15: Convergent rounding at exactly 0x8000 increments only when bit 16 set.
// RULE16: Plain store truncates, rounded store rounds, write-back always rounds.
// RULE17: Store clipping forces 0x7FFF or 0x8000, accumulator left untouched.
// RULE18: Store clipping takes operand sign from accumulator bit 39.
// RULE19: Store clipping off passes rounded value unchanged.
// RULE20: Shifter does right arithmetic, right logical or left up to 16 in one cycle.
// RULE21: Signed amount: positive right, negative left, zero unchanged.
// RULE22: 40-bit shifter; X data at bits 16..31 right, 0..15 left.
// RULE23: Clip enables at config bits 7:6, width select at bit 4.
// RULE24: Guard flag set when guard bits 32..39 differ after an adder pass.
// RULE25: Enabled 40-bit is super, enabled 32-bit is bit 31, disabled is wrap.
module dap_post_proc (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [4:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  input  wire logic              add_valid_in,
  input  wire logic              add_acc_sel_in,
  input  wire logic [39:0]       add_sum_in,
  input  wire logic              add_ovf39_in,
  input  wire logic              store_req_in,
  input  wire logic              store_rnd_in,
  input  wire logic              store_acc_sel_in,
  input  wire logic [15:0]       store_addr_in,
  input  wire logic              mac_wb_in,
  input  wire dap_pkg::dap_op_t  mac_op_in,
  input  wire logic              mac_acc_sel_in,
  input  wire logic              wb_postinc_in,
  input  wire logic              shift_req_in,
  input  wire dap_pkg::dap_src_t shift_src_in,
  input  wire logic              shift_arith_in,
  input  wire logic [5:0]        shift_amt_in,
  input  wire logic [15:0]       shift_xdata_in,
  output logic      [39:0]       acc_a_out,
  output logic      [39:0]       acc_b_out,
  output logic                   xbus_wr_out,
  output logic      [15:0]       xbus_addr_out,
  output logic      [15:0]       xbus_data_out,
  output logic                   trap_req_out,
  output logic                   shift_valid_out,
  output logic      [39:0]       shift_result_out,
  output logic      [15:0]       shift_word_out
);
  import dap_pkg::*;

  logic [7:0]  cfg_ff;
  logic        trap_en_ff;
  logic        clip_a_ff;
  logic        clip_b_ff;
  logic        grd_a_ff;
  logic        grd_b_ff;
  logic [15:0] ptr_ff;
  logic [39:0] acc_a_ff;
  logic [39:0] acc_b_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic        xwr_ff;
  logic [15:0] xaddr_ff;
  logic [15:0] xdata_ff;
  logic        trap_ff;
  logic        sh_vld_ff;
  logic [39:0] sh_res_ff;
  logic [15:0] sh_word_ff;

  //////////////////////////////////////////////////////////////////////////
  // Rounding and store clipping
  function automatic logic [24:0] dap_round(input logic [39:0] a,
                                            input logic rnd,
                                            input logic conv);
    logic inc;
    inc = 1'b0;
    if (rnd) begin
      inc = a[15]; // RULE14
      if (conv && a[15:0] == `DAP_HALF_LSW) begin
        inc = a[16]; // RULE15
      end
    end
    dap_round = {a[39], a[39:16]} + {24'h000000, inc}; // RULE13
  endfunction

  function automatic logic [15:0] dap_wsat(input logic [39:0] a,
                                           input logic [24:0] r,
                                           input logic en);
    dap_wsat = r[15:0]; // RULE19
    if (en && !a[39] && (|r[23:15])) begin
      dap_wsat = `DAP_WMAX; // RULE17 RULE18
    end
    if (en && a[39] && !(&r[23:15])) begin
      dap_wsat = `DAP_WMIN; // RULE17 RULE18
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Mode decode and adder pass
  logic        clipa_en;
  logic        clipb_en;
  logic        wide_sel;
  logic        sat_en;
  logic        grd_ovf;
  logic        b31_ovf;
  logic        true_neg;
  logic        nxt_clip;
  logic        nxt_grd;
  logic [39:0] nxt_acc;

  assign clipa_en = cfg_ff[`DAP_CLIPA_EN_BIT]; // RULE23
  assign clipb_en = cfg_ff[`DAP_CLIPB_EN_BIT]; // RULE23
  assign wide_sel = cfg_ff[`DAP_WIDTH_BIT]; // RULE23
  assign sat_en   = add_acc_sel_in ? clipb_en : clipa_en;
  assign grd_ovf  = !((&add_sum_in[39:32]) || !(|add_sum_in[39:32])); // RULE24
  assign b31_ovf  = !((&add_sum_in[39:31]) || !(|add_sum_in[39:31]));
  assign true_neg = add_sum_in[39] ^ add_ovf39_in;

  always_comb begin
    nxt_acc  = add_sum_in;
    nxt_clip = 1'b0;
    nxt_grd  = grd_ovf;
    if (sat_en && wide_sel) begin // RULE25
      if (add_ovf39_in) begin
        nxt_acc  = true_neg ? `DAP_MIN40 : `DAP_MAX40; // RULE5
        nxt_clip = 1'b1; // RULE5
      end
    end else if (sat_en) begin
      nxt_grd = 1'b0; // RULE7
      if (add_ovf39_in || b31_ovf) begin
        nxt_acc  = true_neg ? `DAP_MIN32 : `DAP_MAX32; // RULE6
        nxt_clip = 1'b1; // RULE6
      end
    end else begin
      nxt_clip = add_ovf39_in; // RULE2 RULE8
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_a_ff <= '0;
      acc_b_ff <= '0;
    end else if (add_valid_in) begin
      if (add_acc_sel_in) begin
        acc_b_ff <= nxt_acc;
      end else begin
        acc_a_ff <= nxt_acc;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Avalon slave
  logic        acc_ok;
  logic        wr_ok;
  logic [2:0]  widx;
  logic [31:0] rd_mux;
  logic        clr_a;
  logic        clr_b;

  assign acc_ok = (avs_read_in || avs_write_in) && !wait_ff;
  assign wr_ok  = acc_ok && avs_write_in;
  assign widx   = avs_address_in[4:2];
  assign clr_a  = wr_ok && widx == `DAP_STAT_IDX && avs_byteenable_in[0]
                  && avs_writedata_in[`DAP_ST_CLIPA_BIT];
  assign clr_b  = wr_ok && widx == `DAP_STAT_IDX && avs_byteenable_in[0]
                  && avs_writedata_in[`DAP_ST_CLIPB_BIT];

  always_comb begin
    rd_mux = '0;
    case (widx)
      `DAP_CFG_IDX: rd_mux[7:0] = cfg_ff;
      `DAP_INT_IDX: rd_mux[`DAP_TRAP_EN_BIT] = trap_en_ff;
      `DAP_STAT_IDX: begin
        rd_mux[`DAP_ST_CLIPA_BIT] = clip_a_ff;
        rd_mux[`DAP_ST_CLIPB_BIT] = clip_b_ff;
        rd_mux[`DAP_ST_GRDA_BIT]  = grd_a_ff;
        rd_mux[`DAP_ST_GRDB_BIT]  = grd_b_ff;
        rd_mux[`DAP_ST_ANYG_BIT]  = grd_a_ff | grd_b_ff; // RULE4
        rd_mux[`DAP_ST_ANYC_BIT]  = clip_a_ff | clip_b_ff; // RULE4
        rd_mux[`DAP_ST_TRAP_BIT]  = trap_ff;
      end
      `DAP_PTR_IDX: rd_mux[15:0] = ptr_ff;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
    end else begin
      wait_ff  <= !((avs_read_in || avs_write_in) && wait_ff);
      rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_ff     <= `DAP_CFG_RST;
      trap_en_ff <= 1'b0;
    end else if (wr_ok && avs_byteenable_in[0]) begin
      if (widx == `DAP_CFG_IDX) begin
        cfg_ff <= avs_writedata_in[7:0];
      end
      if (widx == `DAP_INT_IDX) begin
        trap_en_ff <= avs_writedata_in[`DAP_TRAP_EN_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status flags and trap request
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clip_a_ff <= 1'b0;
      clip_b_ff <= 1'b0;
    end else begin
      clip_a_ff <= (clip_a_ff && !clr_a)
                   || (add_valid_in && !add_acc_sel_in && nxt_clip); // RULE1
      clip_b_ff <= (clip_b_ff && !clr_b)
                   || (add_valid_in && add_acc_sel_in && nxt_clip); // RULE1
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      grd_a_ff <= 1'b0;
      grd_b_ff <= 1'b0;
    end else begin
      if (clipa_en && !wide_sel) begin
        grd_a_ff <= 1'b0; // RULE7
      end else if (add_valid_in && !add_acc_sel_in) begin
        grd_a_ff <= nxt_grd; // RULE24
      end
      if (clipb_en && !wide_sel) begin
        grd_b_ff <= 1'b0; // RULE7
      end else if (add_valid_in && add_acc_sel_in) begin
        grd_b_ff <= nxt_grd; // RULE24
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      trap_ff <= 1'b0;
    end else begin
      trap_ff <= trap_en_ff && ((clip_a_ff && !clipa_en)
                 || (clip_b_ff && !clipb_en)); // RULE3 RULE9
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Store and post-increment write-back over the X bus, register-direct write-back into the pointer register
  logic        wb_ok;
  logic [39:0] st_src;
  logic [39:0] wb_src;
  logic [15:0] st_word;
  logic [15:0] wb_word;

  assign wb_ok   = mac_wb_in && mac_op_in != dap_op_multiply
                   && mac_op_in != dap_op_neg_multiply
                   && mac_op_in != dap_op_sq_dist
                   && mac_op_in != dap_op_sq_dist_acc; // RULE10
  assign st_src  = store_acc_sel_in ? acc_b_ff : acc_a_ff;
  assign wb_src  = mac_acc_sel_in ? acc_a_ff : acc_b_ff; // RULE10
  assign st_word = dap_wsat(st_src, dap_round(st_src, store_rnd_in, !cfg_ff[`DAP_RND_BIT]),
                            cfg_ff[`DAP_WCLIP_EN_BIT]); // RULE16
  assign wb_word = dap_wsat(wb_src, dap_round(wb_src, 1'b1, !cfg_ff[`DAP_RND_BIT]),
                            cfg_ff[`DAP_WCLIP_EN_BIT]); // RULE16

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      xwr_ff   <= 1'b0;
      xaddr_ff <= '0;
      xdata_ff <= '0;
    end else begin
      xwr_ff <= 1'b0;
      if (store_req_in) begin
        xwr_ff   <= 1'b1;
        xaddr_ff <= store_addr_in;
        xdata_ff <= st_word; // RULE16
      end else if (wb_ok && wb_postinc_in) begin
        xwr_ff   <= 1'b1;
        xaddr_ff <= ptr_ff; // RULE12
        xdata_ff <= wb_word;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_ff <= `DAP_PTR_RST;
    end else if (wr_ok && widx == `DAP_PTR_IDX) begin
      if (avs_byteenable_in[0]) begin
        ptr_ff[7:0] <= avs_writedata_in[7:0];
      end
      if (avs_byteenable_in[1]) begin
        ptr_ff[15:8] <= avs_writedata_in[15:8];
      end
    end else if (wb_ok && !wb_postinc_in) begin
      ptr_ff <= wb_word; // RULE11
    end else if (wb_ok && !store_req_in) begin
      ptr_ff <= ptr_ff + `DAP_PTR_STEP; // RULE12
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Barrel shifter
  logic [5:0]  amt_abs;
  logic [4:0]  mag;
  logic        go_left;
  logic [39:0] sh_op;
  logic [39:0] nxt_sh;

  assign go_left = shift_amt_in[5]; // RULE21
  assign amt_abs = go_left ? 6'(-shift_amt_in) : shift_amt_in;
  assign mag     = (amt_abs > 6'({1'b0, `DAP_SHIFT_MAX})) ? `DAP_SHIFT_MAX : amt_abs[4:0];

  always_comb begin
    case (shift_src_in)
      dap_src_acc_a: sh_op = acc_a_ff;
      dap_src_acc_b: sh_op = acc_b_ff;
      dap_src_xbus: begin
        if (go_left) begin
          sh_op = {24'h000000, shift_xdata_in}; // RULE22
        end else begin
          sh_op = {{8{shift_arith_in & shift_xdata_in[15]}}, shift_xdata_in,
                   16'h0000}; // RULE22
        end
      end
      default: sh_op = '0;
    endcase
    if (go_left) begin
      nxt_sh = sh_op << mag; // RULE20
    end else if (shift_arith_in) begin
      nxt_sh = 40'($signed(sh_op) >>> mag); // RULE20
    end else begin
      nxt_sh = sh_op >> mag; // RULE20 RULE21
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sh_vld_ff  <= 1'b0;
      sh_res_ff  <= '0;
      sh_word_ff <= '0;
    end else begin
      sh_vld_ff <= shift_req_in;
      if (shift_req_in) begin
        sh_res_ff  <= nxt_sh;
        sh_word_ff <= go_left ? nxt_sh[15:0] : nxt_sh[31:16]; // RULE22
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata_out    = rdata_ff;
  assign avs_waitrequest_out = wait_ff;
  assign acc_a_out           = acc_a_ff;
  assign acc_b_out           = acc_b_ff;
  assign xbus_wr_out         = xwr_ff;
  assign xbus_addr_out       = xaddr_ff;
  assign xbus_data_out       = xdata_ff;
  assign trap_req_out        = trap_ff;
  assign shift_valid_out     = sh_vld_ff;
  assign shift_result_out    = sh_res_ff;
  assign shift_word_out      = sh_word_ff;
endmodule

/* File: dv/dap_xbus_model.sv */
// X data bus model that records word writes from the block
`timescale 1ns/1ps
module dap_xbus_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        wr_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] data_in,
  output logic      [15:0] last_addr_out,
  output logic      [15:0] last_data_out,
  output logic      [15:0] count_out
);
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= 16'h0000;
    end else if (wr_in === 1'b1) begin
      last_addr_out <= addr_in;
      last_data_out <= data_in;
      count_out <= count_out + 16'h0001;
    end
  end
endmodule

/* File: dv/dap_post_proc_monitor.sv */
// Concurrent checks on the ports of the accumulator post-processing block
`timescale 1ns/1ps
`include "dap_defines.svh"
module dap_post_proc_monitor
  import dap_pkg::*;
(
  input wire logic             clk_in,
  input wire logic             rst_in,
  input wire logic [4:0]       avs_address_in,
  input wire logic             avs_write_in,
  input wire logic [31:0]      avs_writedata_in,
  input wire logic [3:0]       avs_byteenable_in,
  input wire logic             avs_waitrequest_out,
  input wire logic             add_valid_in,
  input wire logic             add_acc_sel_in,
  input wire logic [39:0]      add_sum_in,
  input wire logic             add_ovf39_in,
  input wire logic             store_req_in,
  input wire logic             mac_wb_in,
  input wire dap_pkg::dap_op_t mac_op_in,
  input wire logic             wb_postinc_in,
  input wire logic [39:0]      acc_a_out,
  input wire logic [39:0]      acc_b_out,
  input wire logic             xbus_wr_out,
  input wire logic             trap_req_out
);
  logic [7:0] cfg_ff;
  logic       ten_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of config and trap enable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_ff <= `DAP_CFG_RST;
      ten_ff <= 1'b0;
    end else if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]) begin
      if (avs_address_in[4:2] == `DAP_CFG_IDX) cfg_ff <= avs_writedata_in[7:0];
      if (avs_address_in[4:2] == `DAP_INT_IDX) ten_ff <= avs_writedata_in[`DAP_TRAP_EN_BIT];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_sat40_value: assert property (
    add_valid_in && !add_acc_sel_in && cfg_ff[7] && cfg_ff[4] && add_ovf39_in
    |=> acc_a_out == ($past(add_sum_in[39]) ? `DAP_MAX40 : `DAP_MIN40))
    else $error("first accumulator 40-bit clip value wrong");
  a_sat32_value: assert property (
    add_valid_in && add_acc_sel_in && cfg_ff[6] && !cfg_ff[4]
    && (add_ovf39_in || (add_sum_in[39:31] != 9'h000 && add_sum_in[39:31] != 9'h1FF))
    |=> acc_b_out == ($past(add_sum_in[39] ^ add_ovf39_in) ? `DAP_MIN32 : `DAP_MAX32))
    else $error("second accumulator 32-bit clip value wrong");
  a_wrap_value: assert property (
    add_valid_in && !add_acc_sel_in && !cfg_ff[7] |=> acc_a_out == $past(add_sum_in))
    else $error("unsaturated accumulator not loaded with sum");
  a_trap_raise: assert property (
    add_valid_in && !add_acc_sel_in && !cfg_ff[7] && ten_ff && add_ovf39_in
    |=> ##1 trap_req_out)
    else $error("trap not raised after overflow");
  a_trap_quiet: assert property (
    !ten_ff && !$past(ten_ff) |-> !trap_req_out)
    else $error("trap raised while disabled");
  a_store_write: assert property (
    store_req_in |=> xbus_wr_out)
    else $error("store gave no bus write");
  a_wb_direct: assert property (
    mac_wb_in && !wb_postinc_in && !store_req_in |=> !xbus_wr_out)
    else $error("register direct write-back wrote the bus");
  a_bus_answer: assert property (
    (avs_write_in && avs_waitrequest_out) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer timing wrong");
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the accumulator post-processing block
`timescale 1ns/1ps
`include "dap_defines.svh"
module tb;
  import dap_pkg::*;
  logic        clk_in = 1'b0, rst_in = 1'b1, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic        add_valid_in, add_acc_sel_in, add_ovf39_in, store_req_in, store_rnd_in;
  logic        store_acc_sel_in, mac_wb_in, mac_acc_sel_in, wb_postinc_in, shift_req_in;
  logic        shift_arith_in, xbus_wr_out, trap_req_out, shift_valid_out;
  logic [3:0]  avs_byteenable_in;
  logic [4:0]  avs_address_in;
  logic [5:0]  shift_amt_in, a6;
  logic [15:0] store_addr_in, shift_xdata_in, xbus_addr_out, xbus_data_out, shift_word_out;
  logic [15:0] m_addr, m_data, m_cnt, p, n0;
  logic [31:0] avs_writedata_in, avs_readdata_out, q, rng = 32'h8A15C46E;
  logic [39:0] add_sum_in, acc_a_out, acc_b_out, shift_result_out, v, w, x, s, ex;
  logic [39:0] crn [4] = '{40'h0012348000, 40'h0012358000, 40'h007FFF8000, 40'hFF7FFF0000};
  logic [5:0]  amc [4] = '{6'h00, 6'h10, 6'h30, 6'h14};
  dap_op_t     mac_op_in;
  dap_src_t    shift_src_in;
  int          err_total = 0, cmp_count = 0, i;
  dap_post_proc u_dap_post_proc (.*);
  dap_xbus_model u_dap_xbus_model (.clk_in, .rst_in, .wr_in(xbus_wr_out),
    .addr_in(xbus_addr_out), .data_in(xbus_data_out), .last_addr_out(m_addr),
    .last_data_out(m_data), .count_out(m_cnt));
  always #25 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [15:0] es(input logic [39:0] a, input logic r, c, k);
    logic [24:0] t;
    t = {a[39], a[39:16]} + 25'(r && (c ? a[15] : a[15:0] > 16'h8000 ||
        (a[15:0] == 16'h8000 && a[16])));
    if (k && !a[39] && t[23:15] != 9'h000) return 16'h7FFF;
    if (k && a[39] && t[23:15] != 9'h1FF) return 16'h8000;
    return t[15:0];
  endfunction
  function automatic logic [39:0] esh(input logic [39:0] d, input logic xb, ar,
                                      input logic [5:0] n);
    logic [39:0] o;
    int          m;
    m = n[5] ? 64 - n : n;
    if (m > 16) m = 16;
    if (n[5]) return (xb ? {24'h0, d[15:0]} : d) << m;
    o = xb ? {{8{ar & d[15]}}, d[15:0], 16'h0} : d;
    return ar ? 40'($signed(o) >>> m) : o >> m;
  endfunction
  task chk(input string nm, input logic [39:0] seen, input logic [39:0] exv);
    cmp_count++;
    if (seen !== exv) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exv, seen);
    end
  endtask
  task report_and_stop();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
    q = avs_readdata_out;
    {avs_write_in, avs_read_in} <= 2'b00;
    @(posedge clk_in);
  endtask
  task pass(input logic sel, input logic [39:0] sum, input logic o);
    {add_valid_in, add_acc_sel_in, add_sum_in, add_ovf39_in} <= {1'b1, sel, sum, o};
    @(posedge clk_in);
    add_valid_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task pulse3(input logic st, input logic r, input dap_op_t op, input logic pi);
    {store_req_in, store_rnd_in, mac_wb_in, wb_postinc_in} <= {st, r, !st, pi};
    mac_op_in <= op;
    @(posedge clk_in);
    {store_req_in, mac_wb_in} <= 2'b00;
    repeat (2) @(posedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
  initial begin
    {avs_read_in, avs_write_in, add_valid_in, add_acc_sel_in, add_ovf39_in, store_req_in,
     store_rnd_in, store_acc_sel_in, mac_wb_in, wb_postinc_in, shift_req_in} = '0;
    {shift_arith_in, avs_address_in, avs_writedata_in, add_sum_in, shift_amt_in} = '0;
    {avs_byteenable_in, store_addr_in, shift_xdata_in, mac_acc_sel_in} = {4'hF, 16'h0200, 17'h1};
    mac_op_in = dap_op_mac_acc;
    shift_src_in = dap_src_acc_a;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    for (i = 0; i < 3; i++) begin
      bus(1'b0, 5'(i * 12 + (i / 2) * 4), 32'h0);
      chk("reset_read", q, 40'h0);
    end
    bus(1'b1, 5'h00, 32'hD0);
    bus(1'b1, 5'h04, 32'h1);
    pass(1'b0, 40'h8000000001, 1'b1);
    chk("sat40a", acc_a_out, `DAP_MAX40);
    pass(1'b1, 40'h7FFFFFFFFF, 1'b1);
    chk("sat40b", acc_b_out, `DAP_MIN40);
    pass(1'b0, 40'h10, 1'b0);
    chk("trap_sat", trap_req_out, 40'h0);
    bus(1'b0, 5'h08, 32'h0);
    chk("sticky", {q[5], q[1:0]}, 40'h7);
    bus(1'b1, 5'h08, 32'h3);
    bus(1'b0, 5'h08, 32'h0);
    chk("clr", q[1:0], 40'h0);
    bus(1'b1, 5'h00, 32'hC0);
    pass(1'b0, 40'h0080000000, 1'b0);
    chk("sat32a", acc_a_out, `DAP_MAX32);
    pass(1'b1, 40'hFF00000000, 1'b0);
    chk("sat32b", acc_b_out, `DAP_MIN32);
    bus(1'b0, 5'h08, 32'h0);
    chk("grd32", q[4:0], 40'h3);
    bus(1'b1, 5'h08, 32'h3);
    bus(1'b1, 5'h00, 32'h0);
    pass(1'b0, 40'h8000000001, 1'b1);
    chk("wrap", acc_a_out, 40'h8000000001);
    @(posedge clk_in);
    chk("trap", trap_req_out, 40'h1);
    pass(1'b0, 40'h0100000000, 1'b0);
    bus(1'b0, 5'h08, 32'h0);
    chk("ovf_grd", {q[4], q[2], q[0]}, 40'h7);
    bus(1'b1, 5'h04, 32'h0);
    bus(1'b1, 5'h08, 32'h3);
    chk("trap_off", trap_req_out, 40'h0);
    for (i = 0; i < 24; i++) begin
      x = 40'(xs());
      v = i < 4 ? crn[i] : {xs(), 8'h00} ^ 40'(xs());
      if (i < 4) x[2:0] = {i[1], i[1], 1'b1};
      bus(1'b1, 5'h00, {26'h0, x[2], 3'h0, x[1], 1'b0});
      store_acc_sel_in <= x[3];
      pass(x[3], v, 1'b0);
      n0 = m_cnt;
      pulse3(1'b1, x[0], dap_op_mac_acc, 1'b1);
      chk("st_data", m_data, es(v, x[0], x[1], x[2]));
      chk("st_addr", m_addr, store_addr_in);
      chk("st_cnt", m_cnt, 40'(n0 + 16'h1));
      chk("st_src", x[3] ? acc_b_out : acc_a_out, v);
    end
    bus(1'b1, 5'h00, 32'h02);
    bus(1'b1, 5'h0C, 32'h0100);
    p = 16'h0100;
    v = 40'h00ABCD8000;
    pass(1'b0, v, 1'b0);
    for (i = 0; i < 8; i++) begin
      n0 = m_cnt;
      pulse3(1'b0, 1'b0, dap_op_t'(i[2:0]), 1'b1);
      chk("wb_cnt", m_cnt, 40'(n0 + 16'(i < 4)));
      if (i < 4) begin
        chk("wb_data", {m_addr, m_data}, {p, es(v, 1'b1, 1'b1, 1'b0)});
        p = p + `DAP_PTR_STEP;
      end
      bus(1'b0, 5'h0C, 32'h0);
      chk("wb_ptr", q, p);
    end
    pulse3(1'b0, 1'b0, dap_op_mac_sub, 1'b0);
    bus(1'b0, 5'h0C, 32'h0);
    chk("wb_reg", q, es(v, 1'b1, 1'b1, 1'b0));
    w = 40'h8123456789;
    pass(1'b1, w, 1'b0);
    for (i = 0; i < 24; i++) begin
      x = 40'(xs());
      a6 = i < 4 ? amc[i] : x[5:0];
      s = i % 3 == 0 ? v : i % 3 == 1 ? w : {24'h0, x[31:16]};
      {shift_req_in, shift_arith_in, shift_amt_in, shift_xdata_in} <= {1'b1, x[6], a6, x[31:16]};
      shift_src_in <= dap_src_t'(i % 3);
      @(posedge clk_in);
      shift_req_in <= 1'b0;
      @(posedge clk_in);
      ex = esh(s, i % 3 == 2, x[6], a6);
      chk("shift", shift_result_out, ex);
      chk("shift_word", {shift_valid_out, shift_word_out},
          {1'b1, a6[5] ? ex[15:0] : ex[31:16]});
    end
    report_and_stop();
  end
endmodule
bind dap_post_proc dap_post_proc_monitor u_dap_post_proc_monitor (.*);
